// File: src/uabw_pkg.sv
// constants and carrier types for the uart baud, address filter and wake-up block
// assumes a single 100 MHz system clock and an 8-bit register port
package uabw_pkg;

  // register indices on the plain register port
  localparam logic [2:0] UABW_ADDR_CTRL_ONE  = 3'h0;
  localparam logic [2:0] UABW_ADDR_CTRL_TWO  = 3'h1;
  localparam logic [2:0] UABW_ADDR_SW_CFG    = 3'h2;
  localparam logic [2:0] UABW_ADDR_DATA      = 3'h3;
  localparam logic [2:0] UABW_ADDR_DIVISOR   = 3'h4;
  localparam logic [2:0] UABW_ADDR_STATUS    = 3'h5;

  // uart_control_one field positions
  localparam int UABW_C1_GLOBAL_EN   = 7;
  localparam int UABW_C1_NINTH_SEL   = 6;
  localparam int UABW_C1_RX_NINTH    = 1;
  localparam int UABW_C1_TX_NINTH    = 0;

  // uart_control_two field positions
  localparam int UABW_C2_TX_EN       = 7;
  localparam int UABW_C2_RX_EN       = 6;
  localparam int UABW_C2_SPEED       = 5;
  localparam int UABW_C2_ADDR_DET    = 4;
  localparam int UABW_C2_WAKE_EN     = 3;
  localparam int UABW_C2_RX_IRQ      = 2;
  localparam int UABW_C2_IDLE_IRQ    = 1;
  localparam int UABW_C2_EMPTY_IRQ   = 0;

  // status field positions
  localparam int UABW_ST_WAKE        = 4;
  localparam int UABW_ST_OVERRUN     = 3;
  localparam int UABW_ST_RX_AVAIL    = 2;
  localparam int UABW_ST_TX_IDLE     = 1;
  localparam int UABW_ST_TX_EMPTY    = 0;

  // reset values
  localparam logic [7:0] UABW_CTRL_ONE_RST = 8'h00;
  localparam logic [7:0] UABW_CTRL_TWO_RST = 8'h00;
  localparam logic [7:0] UABW_DIVISOR_RST  = 8'h00;

  // prescaler reload values: divide by 64 low speed, 16 high speed
  localparam logic [5:0] UABW_PRE_LOW      = 6'h3f;
  localparam logic [5:0] UABW_PRE_HIGH     = 6'h0f;

  // word handed to the transmit shifter
  typedef struct packed {
    logic       ninth;
    logic [7:0] data;
  } uabw_txword_s;

  // word delivered by the receive shifter
  typedef struct packed {
    logic       valid;
    logic       overrun;
    logic       ninth;
    logic [7:0] data;
  } uabw_rxword_s;

endpackage : uabw_pkg

// File: src/uabw_top.sv
// uart baud generator, address filter, pin wake-up, interrupt enables and data register
// assumes shifters run on clk_sys_i and talk to this block through same-clock strobes;
// the two pin-side inputs come from outside the domain and are synchronised here
//
// Notes on behaviour
// - speed select bit set picks high speed, cleared picks low speed.
// - baud equals clock over 64*(N+1) low speed, 16*(N+1) high speed.
// - a dedicated free-running 8-bit timer sets the baud period.
// - divisor N is an unsigned value from 0 to 255.
// - with address detect on, a word with top bit 1 is an address and interrupts.
// - with address detect on, a word with top bit 0 is dropped; only its overrun bit still sets the overrun flag.
// - wake enabled with uart clock stopped: rx pin falling edge raises wake request.
// - pin wake-up does nothing while the uart clock runs.
// - with wake enable cleared, a falling edge never restarts the uart.
// - receive interrupt enable routes overrun and rx-available flags onto the request.
// - idle enable routes the transmitter idle flag onto the request.
// - empty enable routes the transmit-empty flag onto the request.
// - single wire off: shared pin is only the receiver input.
// - single wire on: shared pin role follows receiver and transmitter enables.
// - single wire with both enables high: shared pin is receiver only.
// - bits 7 to 1 of the single-wire register read as zero.
// - one data register: written byte goes out, read byte came in.
// - ninth-bit select picks 8 or 9 bits; separate rx and tx ninth bits.
// - global disable clears overrun and rx-available flags, tx and rx enables and counters; sets idle and empty.
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
module uabw_top
  import uabw_pkg::*;
(
  // clock, reset, enable
  input  wire logic                 clk_sys_i,
  input  wire logic                 rst_i,
  input  wire logic                 clk_en_i,
  // register port
  input  wire logic [2:0]           addr_i,
  input  wire logic [7:0]           wdata_i,
  input  wire logic                 wr_i,
  input  wire logic                 rd_i,
  output logic      [7:0]           rdata_o,
  // shifter side, same clock
  input  wire uabw_pkg::uabw_rxword_s rx_word_i,
  input  wire logic                 tx_taken_i,
  input  wire logic                 tx_idle_i,
  input  wire logic                 tx_line_i,
  output uabw_pkg::uabw_txword_s    tx_word_o,
  output logic                      tx_word_load_o,
  output logic                      baud_tick_o,
  output logic                      nine_bit_mode_o,
  output logic                      shifter_clear_o,
  // pins and clock status, asynchronous
  input  wire logic                 rxtx_i,
  input  wire logic                 uart_clock_on_i,
  output logic                      rxtx_o,
  output logic                      rxtx_oe_o,
  output logic                      tx_o,
  output logic                      tx_oe_o,
  output logic                      rx_path_en_o,
  // request
  output logic                      irq_o,
  output logic                      wake_req_o
);

  typedef struct packed {
    logic [7:0]   ctrl_one;
    logic [7:0]   ctrl_two;
    logic         single_wire_enable;
    logic [7:0]   rx_data;
    uabw_txword_s tx_word;
    logic [7:0]   divisor;
    logic         ovr;
    logic         rxa;
    logic         idle;
    logic         empty;
    logic         wake;
    logic [5:0]   pre;
    logic [7:0]   tmr;
    logic [1:0]   pin_sync;
    logic [1:0]   clk_sync;
    logic         pin_prev;
    logic [7:0]   rdata;
    logic         load;
    logic         tick;
    logic         irq;
    logic         rxtx;
    logic         rxtx_oe;
    logic         tx;
    logic         tx_oe;
    logic         rx_path;
  } uabw_state_s;

  localparam uabw_state_s UABW_STATE_RST = '{
    ctrl_one: UABW_CTRL_ONE_RST,
    ctrl_two: UABW_CTRL_TWO_RST,
    divisor:  UABW_DIVISOR_RST,
    idle:     1'b1,
    empty:    1'b1,
    pin_sync: 2'h3,
    pin_prev: 1'b1,
    default:  '0
  };

  uabw_state_s st_q;
  uabw_state_s st_d;

  // top bit of a received word depends on the word length
  function automatic logic addr_bit(input uabw_rxword_s w, input logic nine);
    addr_bit = nine ? w.ninth : w.data[7];
  endfunction : addr_bit

  logic en;
  logic nine;
  logic transmitter_enable;
  logic receiver_enable;
  logic wr_data;
  logic rd_data;
  logic accept;
  logic pin_fall;
  logic pre_wrap;

  always_comb begin
    en       = st_q.ctrl_one[UABW_C1_GLOBAL_EN];
    nine     = st_q.ctrl_one[UABW_C1_NINTH_SEL];
    transmitter_enable     = st_q.ctrl_two[UABW_C2_TX_EN];
    receiver_enable     = st_q.ctrl_two[UABW_C2_RX_EN];
    wr_data  = wr_i && (addr_i == UABW_ADDR_DATA);
    rd_data  = rd_i && (addr_i == UABW_ADDR_DATA);
    // only the second synchroniser stage and its delayed copy are looked at
    pin_fall = st_q.pin_prev && !st_q.pin_sync[1];
    pre_wrap = (st_q.pre == 6'h00);
    accept   = rx_word_i.valid && en && receiver_enable
               && (!st_q.ctrl_two[UABW_C2_ADDR_DET] || addr_bit(rx_word_i, nine));

    st_d          = st_q;
    st_d.load     = 1'b0;
    st_d.tick     = 1'b0;
    st_d.pin_sync = {st_q.pin_sync[0], rxtx_i};
    st_d.clk_sync = {st_q.clk_sync[0], uart_clock_on_i};
    st_d.pin_prev = st_q.pin_sync[1];
    st_d.idle     = tx_idle_i;

    // register writes
    if (wr_i) begin
      unique case (addr_i)
        UABW_ADDR_CTRL_ONE: begin
          st_d.ctrl_one[7:2]           = wdata_i[7:2];
          st_d.tx_word.ninth           = wdata_i[UABW_C1_TX_NINTH];
          st_d.ctrl_one[UABW_C1_TX_NINTH] = wdata_i[UABW_C1_TX_NINTH];
        end
        UABW_ADDR_CTRL_TWO: st_d.ctrl_two = wdata_i;
        UABW_ADDR_SW_CFG:   st_d.single_wire_enable      = wdata_i[0];
        UABW_ADDR_DATA: begin
          st_d.tx_word.data = wdata_i;
          st_d.load         = 1'b1;
        end
        UABW_ADDR_DIVISOR:  st_d.divisor  = wdata_i;
        UABW_ADDR_STATUS:   st_d.wake     = st_q.wake && !wdata_i[UABW_ST_WAKE];
        default: ;
      endcase
    end

    // flags: a set in the same cycle as its clear wins
    if (wr_data) begin
      st_d.empty = 1'b0;
    end
    if (tx_taken_i || (wr_i && addr_i == UABW_ADDR_CTRL_TWO && wdata_i[UABW_C2_TX_EN])) begin
      st_d.empty = 1'b1;
    end
    if (rd_data) begin
      st_d.rxa = 1'b0;
      st_d.ovr = 1'b0;
    end
    if (accept) begin
      st_d.rx_data                   = rx_word_i.data;
      st_d.ctrl_one[UABW_C1_RX_NINTH] = rx_word_i.ninth;
      st_d.rxa                       = 1'b1;
    end
    if (rx_word_i.valid && rx_word_i.overrun && en && receiver_enable) begin
      st_d.ovr = 1'b1;
    end

    // pin wake-up only while the uart clock is stopped
    if (!st_q.clk_sync[1] && st_q.ctrl_two[UABW_C2_WAKE_EN] && pin_fall) begin
      st_d.wake = 1'b1;
    end

    // prescaler of 64 or 16, then the 8-bit timer reloaded from the divisor
    if (pre_wrap) begin
      st_d.pre = st_q.ctrl_two[UABW_C2_SPEED] ? UABW_PRE_HIGH : UABW_PRE_LOW;
      if (st_q.tmr == 8'h00) begin
        st_d.tmr  = st_q.divisor;
        st_d.tick = 1'b1;
      end else begin
        st_d.tmr = st_q.tmr - 8'h01;
      end
    end else begin
      st_d.pre = st_q.pre - 6'h01;
    end

    // global disable resets the transfer state and the tx and rx enables but keeps the other configuration
    if (!st_d.ctrl_one[UABW_C1_GLOBAL_EN]) begin
      st_d.ctrl_two[UABW_C2_TX_EN] = 1'b0;
      st_d.ctrl_two[UABW_C2_RX_EN] = 1'b0;
      st_d.rxa   = 1'b0;
      st_d.ovr   = 1'b0;
      st_d.idle  = 1'b1;
      st_d.empty = 1'b1;
      st_d.pre   = 6'h00;
      st_d.tmr   = 8'h00;
      st_d.tick  = 1'b0;
      st_d.load  = 1'b0;
    end

    // request line; a wake event is treated as a receiver-related source
    st_d.irq = (st_q.ctrl_two[UABW_C2_RX_IRQ] && (st_q.ovr || st_q.rxa || st_q.wake))
               || (st_q.ctrl_two[UABW_C2_IDLE_IRQ] && st_q.idle)
               || (st_q.ctrl_two[UABW_C2_EMPTY_IRQ] && st_q.empty);

    // pin roles; receiver wins when both enables are set on one wire
    st_d.rx_path = en && receiver_enable;
    st_d.rxtx_oe = en && st_q.single_wire_enable && transmitter_enable && !receiver_enable;
    st_d.rxtx    = st_q.single_wire_enable ? tx_line_i : 1'b1;
    st_d.tx_oe   = en && transmitter_enable && !st_q.single_wire_enable;
    st_d.tx      = tx_line_i;

    // read data, one cycle after the strobe
    st_d.rdata = 8'h00;
    if (rd_i) begin
      unique case (addr_i)
        UABW_ADDR_CTRL_ONE: st_d.rdata = {st_q.ctrl_one[7:1], 1'b0};
        UABW_ADDR_CTRL_TWO: st_d.rdata = st_q.ctrl_two;
        UABW_ADDR_SW_CFG:   st_d.rdata = {7'h00, st_q.single_wire_enable};
        UABW_ADDR_DATA:     st_d.rdata = st_q.rx_data;
        UABW_ADDR_DIVISOR:  st_d.rdata = st_q.divisor;
        UABW_ADDR_STATUS:   st_d.rdata = {3'h0, st_q.wake, st_q.ovr, st_q.rxa,
                                          st_q.idle, st_q.empty};
        default:            st_d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= UABW_STATE_RST;
    end else if (clk_en_i) begin
      st_q <= st_d;
    end
  end

  assign rdata_o         = st_q.rdata;
  assign tx_word_o       = st_q.tx_word;
  assign tx_word_load_o  = st_q.load;
  assign baud_tick_o     = st_q.tick;
  assign nine_bit_mode_o = st_q.ctrl_one[UABW_C1_NINTH_SEL];
  assign shifter_clear_o = !st_q.ctrl_one[UABW_C1_GLOBAL_EN];
  assign rxtx_o          = st_q.rxtx;
  assign rxtx_oe_o       = st_q.rxtx_oe;
  assign tx_o            = st_q.tx;
  assign tx_oe_o         = st_q.tx_oe;
  assign rx_path_en_o    = st_q.rx_path;
  assign irq_o           = st_q.irq;
  assign wake_req_o      = st_q.wake;

  // checks
  sequence s_pre_wrap;
    clk_en_i && en && (st_q.pre == 6'h00);
  endsequence

  sequence s_tmr_wrap;
    s_pre_wrap ##0 (st_q.tmr == 8'h00);
  endsequence

  a_pre_reload: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_pre_wrap ##0 (!wr_i)
    |=> st_q.pre == ($past(st_q.ctrl_two[UABW_C2_SPEED]) ? UABW_PRE_HIGH : UABW_PRE_LOW))
    else $error("prescaler reload does not follow speed select");

  a_tmr_reload: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_tmr_wrap ##0 (!wr_i) |=> (st_q.tmr == $past(st_q.divisor)) && baud_tick_o)
    else $error("timer did not reload from divisor with a tick");

  a_tick_cause: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    $rose(baud_tick_o) |-> $past(pre_wrap) && ($past(st_q.tmr) == 8'h00) && $past(clk_en_i))
    else $error("baud tick without timer wrap");

  a_addr_drop: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    clk_en_i && rx_word_i.valid && st_q.ctrl_two[UABW_C2_ADDR_DET]
    && !addr_bit(rx_word_i, nine) && !st_q.rxa |=> !st_q.rxa)
    else $error("data word accepted while address detect is on");

  a_addr_take: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    clk_en_i && accept && !wr_i |=> st_q.rxa && (st_q.rx_data == $past(rx_word_i.data)))
    else $error("accepted word not stored");

  a_wake_set: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    clk_en_i && !st_q.clk_sync[1] && st_q.ctrl_two[UABW_C2_WAKE_EN] && pin_fall
    |=> wake_req_o)
    else $error("falling edge did not raise wake request");

  a_wake_block: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (st_q.clk_sync[1] || !st_q.ctrl_two[UABW_C2_WAKE_EN]) && !wake_req_o |=> !wake_req_o)
    else $error("wake request while clock runs or wake disabled");

  a_irq_rx: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    clk_en_i && st_q.ctrl_two[UABW_C2_RX_IRQ] && st_q.rxa |=> irq_o)
    else $error("rx available did not raise request");

  a_irq_quiet: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    clk_en_i && (st_q.ctrl_two[2:0] == 3'h0) |=> !irq_o)
    else $error("request raised with all enables off");

  a_empty_irq: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    clk_en_i && st_q.ctrl_two[UABW_C2_EMPTY_IRQ] && st_q.empty |=> irq_o)
    else $error("empty flag did not raise request");

  a_sw_recv: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    clk_en_i && st_q.single_wire_enable && transmitter_enable && receiver_enable && en |=> !rxtx_oe_o && rx_path_en_o)
    else $error("shared pin driven with both enables set");

  a_sw_read: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    clk_en_i && rd_i && (addr_i == UABW_ADDR_SW_CFG) |=> rdata_o[7:1] == 7'h00)
    else $error("unimplemented single-wire bits read nonzero");

  a_disable: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    clk_en_i && !st_d.ctrl_one[UABW_C1_GLOBAL_EN]
    |=> st_q.empty && st_q.idle && !st_q.rxa && !st_q.ovr && !baud_tick_o)
    else $error("disable did not reset flags");

  a_irq_idle: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    clk_en_i && st_q.ctrl_two[UABW_C2_IDLE_IRQ] && st_q.idle |=> irq_o)
    else $error("idle flag did not raise request");

  a_irq_ovr: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    clk_en_i && st_q.ctrl_two[UABW_C2_RX_IRQ] && st_q.ovr |=> irq_o)
    else $error("overrun did not raise request");

  a_irq_masked: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    clk_en_i && !st_q.ctrl_two[UABW_C2_RX_IRQ]
    && !(st_q.ctrl_two[UABW_C2_IDLE_IRQ] && st_q.idle)
    && !(st_q.ctrl_two[UABW_C2_EMPTY_IRQ] && st_q.empty) |=> !irq_o)
    else $error("flags reached the request with their enables off");

  a_sw_off: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    clk_en_i && !st_q.single_wire_enable |=> !rxtx_oe_o && rxtx_o)
    else $error("shared pin driven outside single wire mode");

  a_sw_tx: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    clk_en_i && en && st_q.single_wire_enable && transmitter_enable && !receiver_enable
    |=> rxtx_oe_o && !tx_oe_o && !rx_path_en_o)
    else $error("single wire transmit role not taken");

  a_data_load: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    clk_en_i && wr_data && st_d.ctrl_one[UABW_C1_GLOBAL_EN]
    |=> tx_word_load_o && (tx_word_o.data == $past(wdata_i)))
    else $error("data write not handed to the transmitter");

  a_data_read: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    clk_en_i && rd_data |=> rdata_o == $past(st_q.rx_data))
    else $error("data read did not return the received byte");

  a_ninth_store: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    clk_en_i && accept && !wr_i
    |=> st_q.ctrl_one[UABW_C1_RX_NINTH] == $past(rx_word_i.ninth))
    else $error("received ninth bit not stored");

  a_tick_gap: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    clk_en_i && baud_tick_o |=> !baud_tick_o)
    else $error("baud tick longer than one cycle");

  a_pre_count: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    clk_en_i && en && !wr_i && !pre_wrap |=> st_q.pre == $past(st_q.pre) - 6'h01)
    else $error("prescaler did not count down");

  a_tmr_hold: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    clk_en_i && en && !wr_i && !pre_wrap |=> $stable(st_q.tmr))
    else $error("timer moved between prescaler wraps");

  a_wake_clear: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    clk_en_i && wr_i && (addr_i == UABW_ADDR_STATUS) && wdata_i[UABW_ST_WAKE] && !pin_fall
    |=> !wake_req_o)
    else $error("wake request not cleared by status write");

  a_clear_out: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    clk_en_i && !en && !st_d.ctrl_one[UABW_C1_GLOBAL_EN]
    |=> shifter_clear_o && !tx_oe_o && !rxtx_oe_o && !rx_path_en_o && !tx_word_load_o)
    else $error("disabled block still drives pins or shifters");

endmodule : uabw_top

// File: sim/uabw_peer.sv
// remote serial peer on the shared rx/tx wire
// assumes the wire idles high through a pull-up and the device wins while it drives
module uabw_peer (
  // clock and request
  input  wire logic clk_sys_i,
  input  wire logic start_i,
  // device side of the shared wire
  input  wire logic dev_out_i,
  input  wire logic dev_oe_i,
  // resolved wire level
  output logic      line_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] low_q = 4'h0;

  // a start bit held for eight cycles gives one clean falling edge, then the pull-up wins
  always_ff @(posedge clk_sys_i) begin
    if (start_i) begin
      low_q <= 4'h8;
    end else if (low_q != 4'h0) begin
      low_q <= low_q - 4'h1;
    end
  end

  assign line_o = dev_oe_i ? dev_out_i : (low_q == 4'h0);
endmodule : uabw_peer

// File: sim/testbench.sv
// self-checking bench for uabw_top: register tasks, receive words, serial peer on the pin
// assumes the register port of the design's package and one 100 MHz clock
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import uabw_pkg::*;

  logic clk_sys_i, rst_i, clk_en_i, wr_i, rd_i, tx_taken_i, tx_idle_i, tx_line_i;
  logic uart_clock_on_i, start, pin_w, rxtx_o, rxtx_oe_o, tx_o, tx_oe_o, rx_path_en_o;
  logic baud_tick_o, tx_word_load_o, nine_bit_mode_o, shifter_clear_o, irq_o, wake_req_o;
  logic [2:0]   addr_i;
  logic [7:0]   wdata_i, rdata_o;
  uabw_rxword_s rx_word_i;
  uabw_txword_s tx_word_o;
  int           fail_count = 0;
  int           comparisons = 0;
  int           cyc = 0;

  uabw_top uabw_top_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .clk_en_i(clk_en_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .rx_word_i(rx_word_i), .tx_taken_i(tx_taken_i), .tx_idle_i(tx_idle_i),
    .tx_line_i(tx_line_i), .tx_word_o(tx_word_o), .tx_word_load_o(tx_word_load_o),
    .baud_tick_o(baud_tick_o), .nine_bit_mode_o(nine_bit_mode_o),
    .shifter_clear_o(shifter_clear_o), .rxtx_i(pin_w), .uart_clock_on_i(uart_clock_on_i),
    .rxtx_o(rxtx_o), .rxtx_oe_o(rxtx_oe_o), .tx_o(tx_o), .tx_oe_o(tx_oe_o),
    .rx_path_en_o(rx_path_en_o), .irq_o(irq_o), .wake_req_o(wake_req_o));

  uabw_peer uabw_peer_i (.clk_sys_i(clk_sys_i), .start_i(start), .dev_out_i(rxtx_o),
    .dev_oe_i(rxtx_oe_o), .line_o(pin_w));

  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  task automatic close_out();
    $display("mismatches %0d comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out

  // the whole run needs a few thousand cycles; a hang is stopped by the cap at 20000 cycles
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      close_out();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rdc(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 chk({8'h00, rdata_o & m}, {8'h00, e});
  endtask : rdc

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : settle

  task automatic rxw(input logic ovr, input logic [7:0] d, input logic nin);
    @(posedge clk_sys_i);
    rx_word_i <= '{1'b1, ovr, nin, d};
    @(posedge clk_sys_i);
    rx_word_i <= '0;
    settle(3);
  endtask : rxw

  task automatic pulse(input logic [1:0] sel);
    @(posedge clk_sys_i);
    if (sel == 2'h0) start <= 1'b1;
    else tx_taken_i <= 1'b1;
    @(posedge clk_sys_i);
    start      <= 1'b0;
    tx_taken_i <= 1'b0;
    settle(12);
  endtask : pulse

  // cycles between two successive baud ticks, bounded both ways
  task automatic per(input int e);
    int n;
    n = 0;
    // only a tick launched after the call counts, so an old setting cannot skew the interval
    do begin
      @(posedge clk_sys_i);
      #1 n++;
    end while (baud_tick_o !== 1'b1 && n < 20000);
    n = 0;
    do begin
      @(posedge clk_sys_i);
      #1 n++;
    end while (baud_tick_o !== 1'b1 && n < 20000);
    chk(n[15:0], e[15:0]);
  endtask : per

  initial begin
    rst_i = 1'b1;
    clk_en_i = 1'b1;
    addr_i = 3'h0;
    wdata_i = 8'h00;
    wr_i = 1'b0;
    rd_i = 1'b0;
    rx_word_i = '0;
    tx_taken_i = 1'b0;
    tx_idle_i = 1'b0;
    tx_line_i = 1'b1;
    uart_clock_on_i = 1'b1;
    start = 1'b0;
    repeat (10) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    rdc(UABW_ADDR_CTRL_TWO, 8'h00, 8'hff);
    rdc(UABW_ADDR_DIVISOR, 8'h00, 8'hff);
    rdc(UABW_ADDR_SW_CFG, 8'h00, 8'hff);
    rdc(3'h6, 8'h00, 8'hff);
    wr(UABW_ADDR_SW_CFG, 8'hff);
    rdc(UABW_ADDR_SW_CFG, 8'h01, 8'hff);
    wr(UABW_ADDR_DIVISOR, 8'hff);
    rdc(UABW_ADDR_DIVISOR, 8'hff, 8'hff);
    wr(UABW_ADDR_CTRL_ONE, 8'h81);
    wr(UABW_ADDR_DIVISOR, 8'h02);
    wr(UABW_ADDR_CTRL_TWO, 8'h20);
    per(48);
    wr(UABW_ADDR_DIVISOR, 8'h01);
    wr(UABW_ADDR_CTRL_TWO, 8'h00);
    per(128);
    wr(UABW_ADDR_DIVISOR, 8'h00);
    wr(UABW_ADDR_CTRL_TWO, 8'h20);
    per(16);
    wr(UABW_ADDR_DATA, 8'ha5);
    #1 chk({6'h00, tx_word_o.ninth, tx_word_load_o, tx_word_o.data}, 16'h03a5);
    // a low enable freezes the load pulse in place
    clk_en_i <= 1'b0;
    settle(3);
    chk({15'h0, tx_word_load_o}, 16'h0001);
    clk_en_i <= 1'b1;
    settle(1);
    chk({15'h0, tx_word_load_o}, 16'h0000);
    // receive flags reach the request only through the receive interrupt enable
    wr(UABW_ADDR_CTRL_TWO, 8'h40);
    rxw(1'b0, 8'h3c, 1'b0);
    chk({15'h0, irq_o}, 16'h0000);
    rdc(UABW_ADDR_STATUS, 8'h04, 8'h04);
    wr(UABW_ADDR_CTRL_TWO, 8'h44);
    settle(2);
    chk({15'h0, irq_o}, 16'h0001);
    rdc(UABW_ADDR_DATA, 8'h3c, 8'hff);
    settle(2);
    chk({15'h0, irq_o}, 16'h0000);
    rxw(1'b1, 8'h11, 1'b0);
    rdc(UABW_ADDR_STATUS, 8'h0c, 8'h0c);
    rdc(UABW_ADDR_DATA, 8'h11, 8'hff);
    // address filter in 8-bit then 9-bit format
    wr(UABW_ADDR_CTRL_TWO, 8'h54);
    rxw(1'b0, 8'h12, 1'b0);
    chk({15'h0, irq_o}, 16'h0000);
    rdc(UABW_ADDR_STATUS, 8'h00, 8'h04);
    rxw(1'b0, 8'h92, 1'b0);
    chk({15'h0, irq_o}, 16'h0001);
    rdc(UABW_ADDR_DATA, 8'h92, 8'hff);
    wr(UABW_ADDR_CTRL_ONE, 8'hc0);
    rxw(1'b0, 8'h80, 1'b0);
    rdc(UABW_ADDR_STATUS, 8'h00, 8'h04);
    chk({14'h0, nine_bit_mode_o, shifter_clear_o}, 16'h0002);
    rxw(1'b0, 8'h05, 1'b1);
    chk({15'h0, irq_o}, 16'h0001);
    rdc(UABW_ADDR_CTRL_ONE, 8'hc2, 8'hff);
    rdc(UABW_ADDR_DATA, 8'h05, 8'hff);
    // empty and idle flags, each under its own enable
    wr(UABW_ADDR_CTRL_TWO, 8'h01);
    settle(2);
    chk({15'h0, irq_o}, 16'h0000);
    pulse(2'h1);
    chk({15'h0, irq_o}, 16'h0001);
    wr(UABW_ADDR_CTRL_TWO, 8'h02);
    settle(2);
    chk({15'h0, irq_o}, 16'h0000);
    tx_idle_i <= 1'b1;
    settle(4);
    chk({15'h0, irq_o}, 16'h0001);
    wr(UABW_ADDR_CTRL_TWO, 8'h00);
    settle(2);
    chk({15'h0, irq_o}, 16'h0000);
    tx_idle_i <= 1'b0;
    // pin roles
    wr(UABW_ADDR_SW_CFG, 8'h00);
    wr(UABW_ADDR_CTRL_TWO, 8'hc0);
    tx_line_i <= 1'b0;
    settle(2);
    chk({11'h0, tx_o, rxtx_o, tx_oe_o, rxtx_oe_o, rx_path_en_o}, 16'h000d);
    wr(UABW_ADDR_SW_CFG, 8'h01);
    wr(UABW_ADDR_CTRL_TWO, 8'h80);
    settle(2);
    chk({11'h0, tx_o, rxtx_o, tx_oe_o, rxtx_oe_o, rx_path_en_o}, 16'h0002);
    wr(UABW_ADDR_CTRL_TWO, 8'hc0);
    settle(2);
    chk({11'h0, tx_o, rxtx_o, tx_oe_o, rxtx_oe_o, rx_path_en_o}, 16'h0001);
    tx_line_i <= 1'b1;
    wr(UABW_ADDR_SW_CFG, 8'h00);
    wr(UABW_ADDR_CTRL_ONE, 8'h40);
    rdc(UABW_ADDR_CTRL_TWO, 8'h00, 8'hc0);
    rdc(UABW_ADDR_STATUS, 8'h03, 8'h0f);
    chk({14'h0, nine_bit_mode_o, shifter_clear_o}, 16'h0003);
    // pin wake-up with the uart clock stopped, then with wake disabled, then with the uart clock running
    wr(UABW_ADDR_CTRL_TWO, 8'h08);
    uart_clock_on_i <= 1'b0;
    settle(4);
    pulse(2'h0);
    rdc(UABW_ADDR_STATUS, 8'h10, 8'h10);
    chk({15'h0, wake_req_o}, 16'h0001);
    wr(UABW_ADDR_STATUS, 8'h10);
    rdc(UABW_ADDR_STATUS, 8'h00, 8'h10);
    wr(UABW_ADDR_CTRL_TWO, 8'h0c);
    pulse(2'h0);
    chk({15'h0, irq_o}, 16'h0001);
    wr(UABW_ADDR_STATUS, 8'h10);
    wr(UABW_ADDR_CTRL_TWO, 8'h00);
    pulse(2'h0);
    rdc(UABW_ADDR_STATUS, 8'h00, 8'h10);
    chk({15'h0, wake_req_o}, 16'h0000);
    wr(UABW_ADDR_CTRL_TWO, 8'h08);
    uart_clock_on_i <= 1'b1;
    settle(4);
    pulse(2'h0);
    rdc(UABW_ADDR_STATUS, 8'h00, 8'h10);
    chk({15'h0, wake_req_o}, 16'h0000);
    close_out();
  end
endmodule : testbench
